// [viak_select.sv]
// Package of constants for the interrupt acknowledge block, and the source selector.
// Assumes one system clock; the selector is purely combinational.
package viak_pkg;
  // Register byte offsets on the APB
  localparam logic [7:0] VIAK_OFS_REQ   = 8'h00;
  localparam logic [7:0] VIAK_OFS_MASK  = 8'h04;
  localparam logic [7:0] VIAK_OFS_PRIO  = 8'h08;
  localparam logic [7:0] VIAK_OFS_PSW   = 8'h0C;
  localparam logic [7:0] VIAK_OFS_STAT  = 8'h10;
  localparam logic [7:0] VIAK_OFS_VBASE = 8'h14;
  // Status word layout and reset value
  localparam int         VIAK_PSW_IE_BIT  = 7;
  localparam int         VIAK_PSW_ISP_BIT = 1;
  localparam logic [7:0] VIAK_PSW_RESET   = 8'h02;
  // Reset values of the mask and priority flag registers and of the vector base
  localparam logic [31:0] VIAK_MASK_RESET = 32'hFFFFFFFF;
  localparam logic [31:0] VIAK_PRIO_RESET = 32'hFFFFFFFF;
  localparam logic [15:0] VIAK_VBASE_RESET = 16'h0004;
  // Software trap vector locations
  localparam logic [15:0] VIAK_TRAP_VEC_LO = 16'h003E;
  localparam logic [15:0] VIAK_TRAP_VEC_HI = 16'h003F;
  // Least request-to-vector times in CPU clocks, and the longest ones
  localparam int VIAK_LAT_MIN_HI = 7;
  localparam int VIAK_LAT_MIN_LO = 8;
  localparam int VIAK_LAT_MAX_HI = 32;
  localparam int VIAK_LAT_MAX_LO = 33;
  // Cycles from the acceptance decision to the vector pulse (flag set takes one)
  localparam logic [3:0] VIAK_DLY_HI = 4'(VIAK_LAT_MIN_HI - 1);
  localparam logic [3:0] VIAK_DLY_LO = 4'(VIAK_LAT_MIN_LO - 1);

  typedef enum logic [2:0] {
    VIAK_ST_IDLE = 3'b001,
    VIAK_ST_WAIT = 3'b010,
    VIAK_ST_VEC  = 3'b100
  } viak_state_t;
endpackage

`timescale 1ns/10ps
module viak_select
  import viak_pkg::*;
#(
  parameter int NSRC = 32
) (
  // Candidates
  input  wire logic [NSRC-1:0]         elig_i,
  input  wire logic [NSRC-1:0]         prio_i,
  input  wire logic                    allow_low_i,
  // Choice
  output logic                         found_o,
  output logic [$clog2(NSRC)-1:0]      idx_o,
  output logic                         prio_o
);
  localparam int IW = $clog2(NSRC);

  // Lowest index wins: index order is the fixed default order
  function automatic logic [IW:0] first_set(input logic [NSRC-1:0] v);
    logic [IW:0] r;
    r = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, IW'(i)};
      end
    end
    return r;
  endfunction

  logic [IW:0] hi_pick;
  logic [IW:0] lo_pick;

  always_comb begin
    hi_pick = first_set(elig_i & ~prio_i);
    lo_pick = first_set(elig_i & prio_i & {NSRC{allow_low_i}});
    if (hi_pick[IW]) begin                                   // RL7
      found_o = 1'b1;
      idx_o   = hi_pick[IW-1:0];
      prio_o  = 1'b0;
    end else if (lo_pick[IW]) begin                          // RL3
      found_o = 1'b1;
      idx_o   = lo_pick[IW-1:0];
      prio_o  = 1'b1;
    end else begin
      found_o = 1'b0;
      idx_o   = '0;
      prio_o  = 1'b0;
    end
  end
endmodule

// [viak_top.sv]
// Interrupt acceptance and nesting for an 8-bit core, with an APB register slave.
// Assumes the core pipeline on the same clock: it reports instruction ends,
// executes the pushes and the vector load on the acknowledge pulses.
//
// Notes on behaviour
// RL1: A source is eligible only with its request flag 1 and mask 0.
// RL2: Maskable requests are accepted only while the global enable is 1.
// RL3: With in-service status 0, low-priority requests are never accepted.
// RL4: High-priority sources vector between 7 and 32 clocks after request.
// RL5: Low-priority sources vector between 8 and 33 clocks after request.
// RL6: A divide in progress delays acceptance until it finishes.
// RL7: Higher priority level wins, ties go to the fixed default order.
// RL8: An unaccepted request stays pending and is taken once conditions hold.
// RL9: Accept pushes status, then PC, clears enable, copies priority, vectors.
// RL10: A maskable handler ends with the vectored return.
// RL11: The software trap is always taken, whatever enable, mask or priority.
// RL12: Trap pushes status, then PC, clears enable, vectors via 003EH/003FH.
// RL13: Software leaves a trap handler with the trap return only.
// RL14: Nesting needs the handler to set the enable again first.
// RL15: Equal or higher priority nests; lower priority stays pending.
// RL16: After a return, one interrupted instruction runs before a pending request.
// RL17: Status 0 nests only priority 0; status 1 nests any; traps always.
// RL18: Status, enable, return and flag-register accesses defer by one instruction.
// RL19: The trap does not defer, but its cleared enable blocks maskables.
// RL20: Priority flags do not affect how request flags are set.
// RL21: In-service status reads 0 in a high-priority handler, else 1.
// RL22: Priority flag 0 is the higher level, 1 the lower.
// RL23: Reset sets the status word to 02H.
// RL24: Both returns and status pop restore the whole status word.
// RL25: Accepting a source clears its request flag.
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
module viak_top
  import viak_pkg::*;
#(
  parameter int NSRC = 32
) (
  // Clock and reset
  input  wire logic                    clk_sys_i,
  input  wire logic                    reset_n_i,
  // APB slave
  input  wire logic                    psel_i,
  input  wire logic                    penable_i,
  input  wire logic                    pwrite_i,
  input  wire logic [7:0]              paddr_i,
  input  wire logic [31:0]             pwdata_i,
  output logic [31:0]                  prdata_o,
  output logic                         pready_o,
  output logic                         pslverr_o,
  // Peripheral request pulses
  input  wire logic [NSRC-1:0]         src_event_i,
  // Core instruction reports
  input  wire logic                    instr_done_i,
  input  wire logic                    instr_hold_i,
  input  wire logic                    trap_exec_i,
  input  wire logic                    enable_instr_i,
  input  wire logic                    disable_instr_i,
  input  wire logic                    psw_load_i,
  input  wire logic [7:0]              psw_load_data_i,
  // Acknowledge to the core
  output logic                         ack_o,
  output logic                         ack_trap_o,
  output logic [7:0]                   ack_push_psw_o,
  output logic [15:0]                  ack_vector_o,
  output logic [$clog2(NSRC)-1:0]      ack_src_o,
  output logic [7:0]                   psw_o
);
  localparam int IW = $clog2(NSRC);

  viak_state_t          state_q;
  viak_state_t          state_d;
  logic [NSRC-1:0]      req_q;
  logic [NSRC-1:0]      mask_q;
  logic [NSRC-1:0]      prio_q;
  logic [7:0]           psw_q;
  logic [15:0]          vbase_q;
  logic                 defer_q;
  logic                 defer_arm_q;
  logic [3:0]           dly_q;
  logic [IW-1:0]        sel_idx_q;
  logic                 sel_prio_q;
  logic                 ack_q;
  logic                 ack_trap_q;
  logic [7:0]           ack_push_psw_q;
  logic [15:0]          ack_vector_q;
  logic [IW-1:0]        ack_src_q;

  logic                 wr_en;
  logic                 rd_en;
  logic                 addr_ok;
  logic                 flag_reg_wr;
  logic [NSRC-1:0]      elig;
  logic                 found;
  logic [IW-1:0]        pick_idx;
  logic                 pick_prio;
  logic                 ie;
  logic                 in_service_priority_status;
  logic                 accept;
  logic [NSRC-1:0]      ack_clr;

  assign ie  = psw_q[VIAK_PSW_IE_BIT];
  assign in_service_priority_status = psw_q[VIAK_PSW_ISP_BIT];

  // APB decode; every access completes in its first access cycle
  always_comb begin
    if (paddr_i == VIAK_OFS_REQ) begin
      addr_ok = 1'b1;
    end else if (paddr_i == VIAK_OFS_MASK) begin
      addr_ok = 1'b1;
    end else if (paddr_i == VIAK_OFS_PRIO) begin
      addr_ok = 1'b1;
    end else if (paddr_i == VIAK_OFS_PSW) begin
      addr_ok = 1'b1;
    end else if (paddr_i == VIAK_OFS_STAT) begin
      addr_ok = 1'b1;
    end else if (paddr_i == VIAK_OFS_VBASE) begin
      addr_ok = 1'b1;
    end else begin
      addr_ok = 1'b0;
    end
  end

  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~addr_ok;
  assign wr_en     = psel_i & penable_i & pwrite_i & addr_ok;
  assign rd_en     = psel_i & ~penable_i & ~pwrite_i;
  assign flag_reg_wr = wr_en & ((paddr_i == VIAK_OFS_REQ) | (paddr_i == VIAK_OFS_MASK) |
                                (paddr_i == VIAK_OFS_PRIO) | (paddr_i == VIAK_OFS_PSW));

  // Read data captured in the setup cycle, stable through the access cycle
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prdata_o <= 32'h00000000;
    end else if (rd_en) begin
      if (paddr_i == VIAK_OFS_REQ) begin
        prdata_o <= 32'(req_q);
      end else if (paddr_i == VIAK_OFS_MASK) begin
        prdata_o <= 32'(mask_q);
      end else if (paddr_i == VIAK_OFS_PRIO) begin
        prdata_o <= 32'(prio_q);
      end else if (paddr_i == VIAK_OFS_PSW) begin
        prdata_o <= {24'h000000, psw_q};                     // RL21
      end else if (paddr_i == VIAK_OFS_STAT) begin
        prdata_o <= {16'h0000, 8'(ack_src_q), 4'h0, found, defer_q,
                     state_q != VIAK_ST_IDLE, ie & found};
      end else if (paddr_i == VIAK_OFS_VBASE) begin
        prdata_o <= {16'h0000, vbase_q};
      end else begin
        prdata_o <= 32'h00000000;
      end
    end
  end

  // Eligibility and nesting choice
  assign elig = req_q & ~mask_q;                             // RL1

  viak_select #(
    .NSRC (NSRC)
  ) u_select (
    .elig_i      (elig),
    .prio_i      (prio_q),                                   // RL22
    .allow_low_i (in_service_priority_status),                                      // RL17
    .found_o     (found),
    .idx_o       (pick_idx),
    .prio_o      (pick_prio)
  );

  // Decisions are made only at an instruction end, so a long divide simply
  // postpones the next chance to accept
  assign accept = (state_q == VIAK_ST_IDLE) & instr_done_i & ~trap_exec_i & // RL6
                  ie & found & ~defer_q;                     // RL2 RL8 RL15

  // Request flags: peripheral events set, software writes, the vector cycle clears the accepted source
  always_comb begin
    ack_clr = '0;
    if (state_q == VIAK_ST_VEC) begin
      ack_clr[sel_idx_q] = 1'b1;                             // RL25
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      req_q <= '0;
    end else if (wr_en && paddr_i == VIAK_OFS_REQ) begin
      req_q <= (pwdata_i[NSRC-1:0] & ~ack_clr) | src_event_i;
    end else begin
      req_q <= (req_q & ~ack_clr) | src_event_i;             // RL20
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mask_q <= VIAK_MASK_RESET[NSRC-1:0];
    end else if (wr_en && paddr_i == VIAK_OFS_MASK) begin
      mask_q <= pwdata_i[NSRC-1:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prio_q <= VIAK_PRIO_RESET[NSRC-1:0];
    end else if (wr_en && paddr_i == VIAK_OFS_PRIO) begin
      prio_q <= pwdata_i[NSRC-1:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      vbase_q <= VIAK_VBASE_RESET;
    end else if (wr_en && paddr_i == VIAK_OFS_VBASE) begin
      vbase_q <= pwdata_i[15:0];
    end
  end

  // Status word
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      psw_q <= VIAK_PSW_RESET;                               // RL23
    end else if (trap_exec_i) begin
      psw_q[VIAK_PSW_IE_BIT] <= 1'b0;                        // RL12 RL19
    end else if (accept) begin
      psw_q[VIAK_PSW_IE_BIT]  <= 1'b0;                       // RL9 RL14
      psw_q[VIAK_PSW_ISP_BIT] <= pick_prio;                  // RL9
    end else if (psw_load_i) begin
      psw_q <= psw_load_data_i;                              // RL24
    end else if (enable_instr_i) begin
      psw_q[VIAK_PSW_IE_BIT] <= 1'b1;                        // RL14
    end else if (disable_instr_i) begin
      psw_q[VIAK_PSW_IE_BIT] <= 1'b0;
    end else if (wr_en && paddr_i == VIAK_OFS_PSW) begin
      psw_q <= pwdata_i[7:0];
    end
  end

  // Deferral: a hold-class instruction (returns included) or a flag-register
  // write blocks acceptance at the end of the following instruction
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      defer_arm_q <= 1'b0;
      defer_q     <= 1'b0;
    end else begin
      if (instr_done_i) begin
        defer_q     <= (instr_hold_i & ~trap_exec_i) | defer_arm_q | flag_reg_wr; // RL18 RL19
        defer_arm_q <= 1'b0;
      end else if (flag_reg_wr) begin
        defer_arm_q <= 1'b1;                                 // RL18
      end
      if (instr_done_i && defer_q && !instr_hold_i) begin
        defer_q <= defer_arm_q | flag_reg_wr;                // RL16
      end
    end
  end

  // Vectoring sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      VIAK_ST_IDLE: begin
        if (accept) begin
          state_d = VIAK_ST_WAIT;
        end
      end
      VIAK_ST_WAIT: begin
        if (dly_q == 4'h1) begin
          state_d = VIAK_ST_VEC;
        end
      end
      VIAK_ST_VEC: begin
        state_d = VIAK_ST_IDLE;
      end
      default: begin
        state_d = VIAK_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= VIAK_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dly_q      <= 4'h0;
      sel_idx_q  <= '0;
      sel_prio_q <= 1'b0;
    end else if (accept) begin
      dly_q      <= pick_prio ? VIAK_DLY_LO - 4'h1 : VIAK_DLY_HI - 4'h1; // RL4 RL5
      sel_idx_q  <= pick_idx;                                // RL7
      sel_prio_q <= pick_prio;
    end else if (state_q == VIAK_ST_WAIT) begin
      dly_q <= dly_q - 4'h1;
    end
  end

  // Acknowledge outputs: pushed status word, vector and source
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_q          <= 1'b0;
      ack_trap_q     <= 1'b0;
      ack_push_psw_q <= 8'h00;
      ack_vector_q   <= 16'h0000;
      ack_src_q      <= '0;
    end else begin
      ack_q      <= 1'b0;
      ack_trap_q <= 1'b0;
      if (trap_exec_i) begin
        ack_trap_q     <= 1'b1;                              // RL11
        ack_push_psw_q <= psw_q;                             // RL12
        ack_vector_q   <= VIAK_TRAP_VEC_LO;                  // RL12
      end else if (accept) begin
        ack_push_psw_q <= psw_q;                             // RL9
      end else if (state_d == VIAK_ST_VEC) begin
        ack_q        <= 1'b1;                                // RL9
        ack_src_q    <= sel_idx_q;
        ack_vector_q <= vbase_q + {15'(sel_idx_q), 1'b0};
      end
    end
  end

  assign ack_o          = ack_q;
  assign ack_trap_o     = ack_trap_q;
  assign ack_push_psw_o = ack_push_psw_q;
  assign ack_vector_o   = ack_vector_q;
  assign ack_src_o      = ack_src_q;
  assign psw_o          = psw_q;
endmodule

// [viak_props.sv]
// Checker for the interrupt acknowledge block: concurrent properties only.
// Assumes it is bound to viak_top and sees nothing but its ports.
`timescale 1ns/10ps
module viak_props
  import viak_pkg::*;
#(
  parameter int NSRC = 32
) (
  // Clock and reset
  input wire logic       clk_sys_i,
  input wire logic       reset_n_i,
  // Core reports
  input wire logic       trap_exec_i,
  input wire logic       enable_instr_i,
  input wire logic       disable_instr_i,
  input wire logic       psw_load_i,
  input wire logic [7:0] psw_load_data_i,
  // Acknowledge side
  input wire logic        ack_o,
  input wire logic        ack_trap_o,
  input wire logic [15:0] ack_vector_o,
  input wire logic [7:0]  psw_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  a_ack_spacing: assert property (ack_o |=> !ack_o [*6])
    else $error("vector pulses closer than the least latency");
  a_trap_taken: assert property (trap_exec_i |=> ack_trap_o)
    else $error("trap not acknowledged on the next cycle");
  a_trap_vector: assert property (ack_trap_o |-> ack_vector_o == VIAK_TRAP_VEC_LO)
    else $error("trap vector wrong");
  a_trap_clears_ie: assert property (trap_exec_i |=> !psw_o[VIAK_PSW_IE_BIT])
    else $error("trap left the global enable set");
  a_reset_psw: assert property ($rose(reset_n_i) |-> psw_o == VIAK_PSW_RESET)
    else $error("status word wrong after reset");
  a_enable_sets: assert property (enable_instr_i && !trap_exec_i && !disable_instr_i
    && !psw_load_i |=> psw_o[VIAK_PSW_IE_BIT])
    else $error("enable instruction did not set the enable");
  a_disable_clears: assert property (disable_instr_i |=> !psw_o[VIAK_PSW_IE_BIT])
    else $error("disable instruction did not clear the enable");
  a_psw_restore: assert property (psw_load_i && !trap_exec_i
    |=> psw_o == $past(psw_load_data_i))
    else $error("status word not restored");

  c_ack: cover property (ack_o);
  c_trap: cover property (ack_trap_o);
  c_ack_high: cover property (ack_o && !psw_o[VIAK_PSW_ISP_BIT]);
endmodule

// [viak_core_model.sv]
// Behavioural core: reports one instruction end per cycle while running and not dividing.
// Assumes the same clock and reset as the acknowledge block.
`timescale 1ns/10ps
module viak_core_model (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Control
  input  wire logic run_i,
  input  wire logic div_i,
  // Instruction end
  output logic      done_o
);
  // A divide in flight reports no end until it finishes
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= run_i && !div_i;
    end
  end
endmodule

// [tb_top.sv]
// Testbench for viak_top: APB register access plus core and source stimulus.
// Assumes zero-wait APB and the core model ending one instruction per cycle.
`timescale 1ns/10ps
module tb_top
  import viak_pkg::*;
;
  localparam int NSRC = 32;
  logic        clk_sys_i, reset_n_i, psel, penable, pwrite, pready, pslverr, err;
  logic        hold, div, run, done, ack, ack_trap, hit;
  logic [7:0]  paddr, ldat, push, processor_status_word;
  logic [31:0] pwdata, prdata, rdat, src_ev;
  logic [3:0]  ops;
  logic [15:0] vec;
  logic [4:0]  asrc;
  int          n_fail, samples_checked, cyc;
  logic [7:0]  ofs [5] = '{VIAK_OFS_REQ, VIAK_OFS_MASK, VIAK_OFS_PRIO, VIAK_OFS_PSW,
                           VIAK_OFS_VBASE};
  logic [31:0] rval [5] = '{32'h0, VIAK_MASK_RESET, VIAK_PRIO_RESET, 32'h2, 32'h4};

  viak_top #(.NSRC(NSRC)) u_dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .src_event_i(src_ev), .instr_done_i(done), .instr_hold_i(hold),
    .trap_exec_i(ops[2]), .enable_instr_i(ops[0]), .disable_instr_i(ops[1]),
    .psw_load_i(ops[3]), .psw_load_data_i(ldat), .ack_o(ack), .ack_trap_o(ack_trap),
    .ack_push_psw_o(push), .ack_vector_o(vec), .ack_src_o(asrc), .psw_o(processor_status_word));
  viak_core_model u_core (.clk_i(clk_sys_i), .rst_n_i(reset_n_i), .run_i(run),
    .div_i(div), .done_o(done));

  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  task give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict();
    end
  end

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do @(posedge clk_sys_i); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("read data", e, rdat);
  endtask

  task op(input int k, input logic [7:0] d);
    @(posedge clk_sys_i);
    ops <= 4'(1 << k); ldat <= d;
    @(posedge clk_sys_i);
    ops <= 4'h0;
  endtask

  task ev(input logic [31:0] b);
    @(posedge clk_sys_i);
    src_ev <= b;
    @(posedge clk_sys_i);
    src_ev <= 32'h0;
  endtask

  task quiet(input int n);
    hit = 1'b0;
    repeat (n) begin
      @(posedge clk_sys_i);
      #1;
      if (ack !== 1'b0) hit = 1'b1;
    end
    chk("no vector", 0, hit);
  endtask

  // Pulse sources, then count cycles up to the vector pulse
  task fire(input logic [31:0] b, input logic [4:0] s, input int lat);
    int c;
    @(posedge clk_sys_i);
    src_ev <= b;
    for (c = 1; c < 60; c++) begin
      @(posedge clk_sys_i);
      src_ev <= 32'h0;
      #1;
      if (ack === 1'b1) break;
    end
    if (lat > 0) chk("latency", lat, c);
    chk("source", s, asrc);
    chk("vector", VIAK_VBASE_RESET + 16'(2 * s), vec);
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {src_ev, hold, div, run, ops, ldat} = '0;
    reset_n_i = 1'b0;
    repeat (20) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 5; i++) rd(ofs[i], rval[i]);
    rd(8'h20, 32'h0);
    chk("error flag", 1, err);
    run <= 1'b1;
    apb(1'b1, VIAK_OFS_MASK, 32'hFFFFFFF0);
    apb(1'b1, VIAK_OFS_PRIO, 32'hFFFFFFF6);
    rd(VIAK_OFS_PRIO, 32'hFFFFFFF6);
    ev(32'h22); quiet(40);
    rd(VIAK_OFS_REQ, 32'h22);
    op(0, 0); fire(0, 1, 0);
    chk("status", 8'h02, processor_status_word);
    chk("pushed", 8'h82, push);
    rd(VIAK_OFS_REQ, 32'h20);
    op(0, 0); fire(1, 0, 7);
    chk("status", 8'h00, processor_status_word);
    op(0, 0); ev(32'h4); quiet(40);
    op(3, 8'h82); fire(0, 2, 0);
    op(3, 8'h82); fire(32'hC, 3, 7);
    op(3, 8'h82); fire(0, 2, 0);
    op(3, 8'h82); fire(32'h2, 1, 8);
    op(3, 8'h82); fire(32'h9, 0, 7);
    op(3, 8'h82); fire(0, 3, 0);
    ev(32'h4); hold <= 1'b1; op(3, 8'h82); hold <= 1'b0;
    fire(0, 2, 7);
    op(2, 0); #1;
    chk("trap", 1, ack_trap);
    chk("trap vector", VIAK_TRAP_VEC_LO, vec);
    op(3, 8'h02);
    op(0, 0); op(1, 0); #1;
    chk("status", 8'h02, processor_status_word);
    give_verdict();
  end
endmodule

bind viak_top viak_props #(.NSRC(NSRC)) u_props (.clk_sys_i(clk_sys_i),
  .reset_n_i(reset_n_i), .trap_exec_i(trap_exec_i), .enable_instr_i(enable_instr_i),
  .disable_instr_i(disable_instr_i), .psw_load_i(psw_load_i),
  .psw_load_data_i(psw_load_data_i), .ack_o(ack_o), .ack_trap_o(ack_trap_o),
  .ack_vector_o(ack_vector_o), .psw_o(psw_o));
